//--- inc/mbas_pkg.sv
/*
  Constants, frame characters and hex helpers for the ASCII slave port.
  Assumes a single 100 MHz clock and an 8N1 serial line at the standard rate.
*/
// Notes on behaviour
// - A write sent to address 255 is obeyed by every slave, with no reply.
// - Address zero is always answered, whatever the stored slave address.
// - A colon always opens a frame.
// - Each byte travels as two upper-case hex characters, high nibble first.
// - Characters are one start bit, eight data bits, no parity, one stop bit.
// - The line runs at 57600 baud.
// - Frame is colon, address, function, values, check pair, then CR and LF.
// - Check byte is two's complement of the 8-bit sum of frame bytes.
// - A received check byte that disagrees with the sum raises an error.
// - Only the master starts exchanges; the slave speaks only in reply.
// - Every addressed request gets a reply, an exception reply if unsupported.
// - Registers are 16 bits; a 32-bit value spans two consecutive registers.
// - Function 03 reads consecutive registers, sixteen at most.
// - Read request: start and count high byte first; reply: byte count, values.
// - Function 06 writes one 16-bit register and echoes the request.
// - Stored register contents are not disturbed by reset, except REG_SLAVE_ADDR, which reloads SLAVE_ADDR_RST.
// - The port works straight after reset with no set-up from the master.
// - The trigger pin is active low and starts a measurement directly.
// - The transmit driver is released whenever the port is not sending.
// - Writing one to register 512 starts the configured measurement.
`default_nettype none
package mbas_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 57600;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int REG_WORDS = 256;
  localparam int REQ_BYTES = 7;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] ADDR_ALL = 8'h00;
  localparam logic [7:0] ADDR_BCAST = 8'hff;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h01;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] MAX_READ = 16'h0010;
  localparam logic [15:0] REG_SLAVE_ADDR = 16'h00a5;
  localparam logic [15:0] REG_START = 16'h0200;
  localparam logic [15:0] START_VALUE = 16'h0001;

  function automatic logic isHex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction : isHex

  function automatic logic [3:0] hexToNib(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction : hexToNib

  function automatic logic [7:0] nibToHex(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : nibToHex
endpackage : mbas_pkg
`default_nettype wire

//--- hdl/mbas_pair_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes both sides share mclk; a stalled reader never loses a word.
*/
`timescale 1ns/100ps
`default_nettype none
module mbas_pair_buf #(
  parameter int WIDTH = 8
) (
  input wire logic mclk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] inData, // Word offered by the writer.
  input wire logic inValid, // Writer offers a word.
  output logic inReady, // Buffer can take a word.
  output logic [WIDTH-1:0] outData, // Oldest stored word.
  output logic outValid, // A word is stored.
  input wire logic outReady // Reader takes the word.
);
  logic [WIDTH-1:0] slot0_ff, slot1_ff, nxt_slot0, nxt_slot1;
  logic [1:0] cnt_ff, nxt_cnt, base;
  logic push, pop;

  assign inReady = (cnt_ff != 2'd2);
  assign outValid = (cnt_ff != 2'd0);
  assign outData = slot0_ff;

  always_comb begin
    push = inValid && inReady;
    pop = outReady && outValid;
    nxt_slot0 = slot0_ff;
    nxt_slot1 = slot1_ff;
    base = pop ? 2'(cnt_ff - 2'd1) : cnt_ff;
    if (pop) begin
      nxt_slot0 = slot1_ff;
    end
    if (push && base == 2'd0) begin
      nxt_slot0 = inData;
    end else if (push) begin
      nxt_slot1 = inData;
    end
    nxt_cnt = 2'(base + {1'b0, push});
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slot0_ff <= '0;
      slot1_ff <= '0;
      cnt_ff <= 2'd0;
    end else begin
      slot0_ff <= nxt_slot0;
      slot1_ff <= nxt_slot1;
      cnt_ff <= nxt_cnt;
    end
  end

  buf_bound_a: assert property (@(posedge mclk) disable iff (!resetn) cnt_ff <= 2'd2)
    else $error("buffer count out of range");
endmodule : mbas_pair_buf
`default_nettype wire

//--- hdl/mbas_slave_port.sv
/*
  ASCII hex serial slave: receives framed requests, checks them, serves
  register reads and writes, and sends framed replies through a buffer.
  Assumes a 100 MHz mclk; rxIn and trigN are asynchronous pins.
*/
`timescale 1ns/100ps
`default_nettype none
module mbas_slave_port #(
  parameter logic [7:0] SLAVE_ADDR_RST = mbas_pkg::SLAVE_ADDR_RST,
  parameter int BIT_CYC = mbas_pkg::BIT_CYC,
  parameter int REG_WORDS = mbas_pkg::REG_WORDS
) (
  input wire logic mclk, // System clock, 100 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic rxIn, // Serial receive pin.
  input wire logic trigN, // Hardware trigger pin, active low.
  output logic txOut, // Serial transmit data.
  output logic txOe, // Transmit driver enable.
  output logic measureStart, // One-cycle measurement start.
  output logic lrcError, // One-cycle check failure.
  output logic [7:0] slaveAddr // Stored slave address.
);
  localparam int AW = $clog2(REG_WORDS);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYC / 2);
  localparam logic [16:0] SPAN_MAX = 17'(REG_WORDS);

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} mbas_rx_t;
  typedef enum {P_IDLE, P_BODY, P_LF} mbas_prs_t;
  typedef enum {R_IDLE, R_COLON, R_HI, R_LO, R_CR, R_LF} mbas_rsp_t;
  typedef enum {T_IDLE, T_START, T_DATA, T_STOP} mbas_tx_t;

  // Pin synchronisers and receiver.
  logic [2:0] rxSy_ff, nxt_rxSy, trSy_ff, nxt_trSy;
  logic rxLvl_ff, nxt_rxLvl, trLvl_ff, nxt_trLvl, trigFall;
  mbas_rx_t rxState_ff, nxt_rxState;
  logic [15:0] rxCnt_ff, nxt_rxCnt;
  logic [2:0] rxBit_ff, nxt_rxBit;
  logic [7:0] rxSh_ff, nxt_rxSh;
  logic rxDone_ff, nxt_rxDone;

  always_comb begin
    nxt_rxSy = {rxSy_ff[1:0], rxIn};
    nxt_trSy = {trSy_ff[1:0], trigN};
    nxt_rxLvl = (rxSy_ff[1] == rxSy_ff[2]) ? rxSy_ff[2] : rxLvl_ff;
    nxt_trLvl = (trSy_ff[1] == trSy_ff[2]) ? trSy_ff[2] : trLvl_ff;
    trigFall = trLvl_ff && (trSy_ff[1] == trSy_ff[2]) && !trSy_ff[2];
    nxt_rxState = rxState_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_rxBit = rxBit_ff;
    nxt_rxSh = rxSh_ff;
    nxt_rxDone = 1'b0;
    case (rxState_ff)
      RX_IDLE: begin
        if (!rxLvl_ff) begin
          nxt_rxState = RX_START;
          nxt_rxCnt = BIT_HALF;
        end
      end
      RX_START: begin
        if (rxCnt_ff != 16'h0000) begin
          nxt_rxCnt = rxCnt_ff - 16'h0001;
        end else if (!rxLvl_ff) begin
          nxt_rxState = RX_DATA;
          nxt_rxCnt = BIT_LAST;
          nxt_rxBit = 3'h0;
        end else begin
          nxt_rxState = RX_IDLE;
        end
      end
      RX_DATA: begin
        if (rxCnt_ff != 16'h0000) begin
          nxt_rxCnt = rxCnt_ff - 16'h0001;
        end else begin
          nxt_rxSh = {rxLvl_ff, rxSh_ff[7:1]};
          nxt_rxCnt = BIT_LAST;
          nxt_rxBit = rxBit_ff + 3'h1;
          if (rxBit_ff == 3'h7) begin
            nxt_rxState = RX_STOP;
          end
        end
      end
      default: begin
        if (rxCnt_ff != 16'h0000) begin
          nxt_rxCnt = rxCnt_ff - 16'h0001;
        end else begin
          nxt_rxDone = rxLvl_ff;
          nxt_rxState = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxSy_ff <= 3'h7;
      trSy_ff <= 3'h7;
      rxLvl_ff <= 1'b1;
      trLvl_ff <= 1'b1;
      rxState_ff <= RX_IDLE;
      rxCnt_ff <= 16'h0000;
      rxBit_ff <= 3'h0;
      rxSh_ff <= 8'h00;
      rxDone_ff <= 1'b0;
    end else begin
      rxSy_ff <= nxt_rxSy;
      trSy_ff <= nxt_trSy;
      rxLvl_ff <= nxt_rxLvl;
      trLvl_ff <= nxt_trLvl;
      rxState_ff <= nxt_rxState;
      rxCnt_ff <= nxt_rxCnt;
      rxBit_ff <= nxt_rxBit;
      rxSh_ff <= nxt_rxSh;
      rxDone_ff <= nxt_rxDone;
    end
  end

  // Frame parser.
  mbas_prs_t pState_ff, nxt_pState;
  logic [7:0] frm_ff [mbas_pkg::REQ_BYTES];
  logic [7:0] nxt_frm [mbas_pkg::REQ_BYTES];
  logic [3:0] nByte_ff, nxt_nByte, hiNib_ff, nxt_hiNib;
  logic half_ff, nxt_half, bad_ff, nxt_bad, reqGo_ff, nxt_reqGo, lrcErr_ff, nxt_lrcErr;
  logic [7:0] sum_ff, nxt_sum, newByte, slaveAddr_ff;
  logic frameOk, addrHit;

  always_comb begin
    nxt_pState = pState_ff;
    nxt_frm = frm_ff;
    nxt_nByte = nByte_ff;
    nxt_hiNib = hiNib_ff;
    nxt_half = half_ff;
    nxt_bad = bad_ff;
    nxt_sum = sum_ff;
    nxt_reqGo = 1'b0;
    nxt_lrcErr = 1'b0;
    newByte = {hiNib_ff, mbas_pkg::hexToNib(rxSh_ff)};
    frameOk = !bad_ff && !half_ff && nByte_ff == 4'(mbas_pkg::REQ_BYTES);
    addrHit = frm_ff[0] == slaveAddr_ff || frm_ff[0] == mbas_pkg::ADDR_ALL
      || frm_ff[0] == mbas_pkg::ADDR_BCAST;
    if (rxDone_ff && rxSh_ff == mbas_pkg::CH_COLON) begin
      nxt_pState = P_BODY;
      nxt_nByte = 4'h0;
      nxt_half = 1'b0;
      nxt_bad = 1'b0;
      nxt_sum = 8'h00;
    end else if (rxDone_ff) begin
      case (pState_ff)
        P_BODY: begin
          if (rxSh_ff == mbas_pkg::CH_CR) begin
            nxt_pState = P_LF;
          end else if (!mbas_pkg::isHex(rxSh_ff)) begin
            nxt_bad = 1'b1;
          end else if (!half_ff) begin
            nxt_hiNib = mbas_pkg::hexToNib(rxSh_ff);
            nxt_half = 1'b1;
          end else begin
            nxt_half = 1'b0;
            nxt_sum = sum_ff + newByte;
            if (nByte_ff < 4'(mbas_pkg::REQ_BYTES)) begin
              nxt_frm[nByte_ff[2:0]] = newByte;
              nxt_nByte = nByte_ff + 4'h1;
            end else begin
              nxt_bad = 1'b1;
            end
          end
        end
        P_LF: begin
          nxt_pState = P_IDLE;
          if (rxSh_ff == mbas_pkg::CH_LF && frameOk) begin
            nxt_reqGo = (sum_ff == 8'h00) && addrHit;
            nxt_lrcErr = (sum_ff != 8'h00);
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pState_ff <= P_IDLE;
      frm_ff <= '{default: 8'h00};
      nByte_ff <= 4'h0;
      hiNib_ff <= 4'h0;
      half_ff <= 1'b0;
      bad_ff <= 1'b0;
      sum_ff <= 8'h00;
      reqGo_ff <= 1'b0;
      lrcErr_ff <= 1'b0;
    end else begin
      pState_ff <= nxt_pState;
      frm_ff <= nxt_frm;
      nByte_ff <= nxt_nByte;
      hiNib_ff <= nxt_hiNib;
      half_ff <= nxt_half;
      bad_ff <= nxt_bad;
      sum_ff <= nxt_sum;
      reqGo_ff <= nxt_reqGo;
      lrcErr_ff <= nxt_lrcErr;
    end
  end

  // Request execution and reply generation.
  logic [15:0] mem [REG_WORDS];
  mbas_rsp_t rState_ff, nxt_rState;
  logic [5:0] rIdx_ff, nxt_rIdx, rLen_ff, nxt_rLen, sub;
  logic [7:0] rSum_ff, nxt_rSum, rAddr_ff, nxt_rAddr, rFunc_ff, nxt_rFunc;
  logic [7:0] rCode_ff, nxt_rCode, nxt_slaveAddr, cur, fn, bufInData, bufOutData;
  logic [15:0] rA_ff, nxt_rA, rV_ff, nxt_rV, reqA, reqV, word;
  logic rExc_ff, nxt_rExc, rRead_ff, nxt_rRead, measure_ff, nxt_measure;
  logic memWe, bufInValid, bufInReady, bufOutValid, bufOutReady;
  logic [16:0] span;

  function automatic logic [15:0] regRead(input logic [15:0] a);
    if (a == mbas_pkg::REG_SLAVE_ADDR) begin
      return {8'h00, slaveAddr_ff};
    end else if ({1'b0, a} < SPAN_MAX) begin
      return mem[a[AW-1:0]];
    end
    return 16'h0000;
  endfunction : regRead

  always_comb begin
    fn = frm_ff[1];
    reqA = {frm_ff[2], frm_ff[3]};
    reqV = {frm_ff[4], frm_ff[5]};
    span = {1'b0, reqA} + {1'b0, reqV};
    nxt_rState = rState_ff;
    nxt_rIdx = rIdx_ff;
    nxt_rLen = rLen_ff;
    nxt_rSum = rSum_ff;
    nxt_rAddr = rAddr_ff;
    nxt_rFunc = rFunc_ff;
    nxt_rCode = rCode_ff;
    nxt_rA = rA_ff;
    nxt_rV = rV_ff;
    nxt_rExc = rExc_ff;
    nxt_rRead = rRead_ff;
    nxt_slaveAddr = slaveAddr_ff;
    nxt_measure = trigFall;
    memWe = 1'b0;
    if (rState_ff == R_IDLE && reqGo_ff) begin
      nxt_rAddr = frm_ff[0];
      nxt_rFunc = fn;
      nxt_rA = reqA;
      nxt_rV = reqV;
      nxt_rIdx = 6'h00;
      nxt_rSum = 8'h00;
      nxt_rExc = 1'b1;
      nxt_rRead = 1'b0;
      nxt_rLen = 6'h03;
      nxt_rCode = mbas_pkg::EXC_FUNC;
      if (fn == mbas_pkg::FN_READ) begin
        if (reqV == 16'h0000 || reqV > mbas_pkg::MAX_READ) begin
          nxt_rCode = mbas_pkg::EXC_VALUE;
        end else if (span > SPAN_MAX) begin
          nxt_rCode = mbas_pkg::EXC_ADDR;
        end else begin
          nxt_rExc = 1'b0;
          nxt_rRead = 1'b1;
          nxt_rLen = 6'h03 + {reqV[4:0], 1'b0};
        end
      end else if (fn == mbas_pkg::FN_WRITE) begin
        nxt_rExc = 1'b0;
        nxt_rLen = 6'h06;
        if (reqA == mbas_pkg::REG_SLAVE_ADDR) begin
          nxt_slaveAddr = reqV[7:0];
        end else if (reqA == mbas_pkg::REG_START) begin
          nxt_measure = nxt_measure || reqV == mbas_pkg::START_VALUE;
        end else if ({1'b0, reqA} < SPAN_MAX) begin
          memWe = 1'b1;
        end else begin
          nxt_rExc = 1'b1;
          nxt_rLen = 6'h03;
          nxt_rCode = mbas_pkg::EXC_ADDR;
        end
      end
      if (frm_ff[0] != mbas_pkg::ADDR_BCAST) begin
        nxt_rState = R_COLON;
      end
    end
    sub = rIdx_ff - 6'h03;
    word = regRead(rA_ff + {11'h000, sub[5:1]});
    if (rIdx_ff == rLen_ff) begin
      cur = 8'h00 - rSum_ff;
    end else if (rIdx_ff == 6'h00) begin
      cur = rAddr_ff;
    end else if (rIdx_ff == 6'h01) begin
      cur = rExc_ff ? (rFunc_ff | mbas_pkg::EXC_FLAG) : rFunc_ff;
    end else if (rIdx_ff == 6'h02) begin
      cur = rExc_ff ? rCode_ff : (rRead_ff ? {rV_ff[6:0], 1'b0} : rA_ff[15:8]);
    end else if (rRead_ff) begin
      cur = sub[0] ? word[7:0] : word[15:8];
    end else if (rIdx_ff == 6'h03) begin
      cur = rA_ff[7:0];
    end else if (rIdx_ff == 6'h04) begin
      cur = rV_ff[15:8];
    end else begin
      cur = rV_ff[7:0];
    end
    bufInValid = (rState_ff != R_IDLE);
    case (rState_ff)
      R_COLON: bufInData = mbas_pkg::CH_COLON;
      R_HI: bufInData = mbas_pkg::nibToHex(cur[7:4]);
      R_LO: bufInData = mbas_pkg::nibToHex(cur[3:0]);
      R_CR: bufInData = mbas_pkg::CH_CR;
      default: bufInData = mbas_pkg::CH_LF;
    endcase
    if (bufInValid && bufInReady) begin
      case (rState_ff)
        R_COLON: nxt_rState = R_HI;
        R_HI: nxt_rState = R_LO;
        R_LO: begin
          if (rIdx_ff == rLen_ff) begin
            nxt_rState = R_CR;
          end else begin
            nxt_rIdx = rIdx_ff + 6'h01;
            nxt_rSum = rSum_ff + cur;
            nxt_rState = R_HI;
          end
        end
        R_CR: nxt_rState = R_LF;
        default: nxt_rState = R_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (memWe) begin
      mem[reqA[AW-1:0]] <= reqV;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rState_ff <= R_IDLE;
      rIdx_ff <= 6'h00;
      rLen_ff <= 6'h00;
      rSum_ff <= 8'h00;
      rAddr_ff <= 8'h00;
      rFunc_ff <= 8'h00;
      rCode_ff <= 8'h00;
      rA_ff <= 16'h0000;
      rV_ff <= 16'h0000;
      rExc_ff <= 1'b0;
      rRead_ff <= 1'b0;
      slaveAddr_ff <= SLAVE_ADDR_RST;
      measure_ff <= 1'b0;
    end else begin
      rState_ff <= nxt_rState;
      rIdx_ff <= nxt_rIdx;
      rLen_ff <= nxt_rLen;
      rSum_ff <= nxt_rSum;
      rAddr_ff <= nxt_rAddr;
      rFunc_ff <= nxt_rFunc;
      rCode_ff <= nxt_rCode;
      rA_ff <= nxt_rA;
      rV_ff <= nxt_rV;
      rExc_ff <= nxt_rExc;
      rRead_ff <= nxt_rRead;
      slaveAddr_ff <= nxt_slaveAddr;
      measure_ff <= nxt_measure;
    end
  end

  mbas_pair_buf #(.WIDTH(8)) txBuf (
    .mclk(mclk),
    .resetn(resetn),
    .inData(bufInData),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .outData(bufOutData),
    .outValid(bufOutValid),
    .outReady(bufOutReady)
  );

  // Serial transmitter.
  mbas_tx_t tState_ff, nxt_tState;
  logic [15:0] tCnt_ff, nxt_tCnt;
  logic [2:0] tBit_ff, nxt_tBit;
  logic [7:0] tSh_ff, nxt_tSh;
  logic txOut_ff, nxt_txOut, txOe_ff, nxt_txOe;

  always_comb begin
    bufOutReady = (tState_ff == T_IDLE);
    nxt_tState = tState_ff;
    nxt_tCnt = (tCnt_ff == 16'h0000) ? BIT_LAST : tCnt_ff - 16'h0001;
    nxt_tBit = tBit_ff;
    nxt_tSh = tSh_ff;
    nxt_txOut = txOut_ff;
    case (tState_ff)
      T_IDLE: begin
        nxt_tCnt = BIT_LAST;
        if (bufOutValid) begin
          nxt_tSh = bufOutData;
          nxt_txOut = 1'b0;
          nxt_tState = T_START;
        end
      end
      T_START: begin
        if (tCnt_ff == 16'h0000) begin
          nxt_txOut = tSh_ff[0];
          nxt_tSh = {1'b0, tSh_ff[7:1]};
          nxt_tBit = 3'h0;
          nxt_tState = T_DATA;
        end
      end
      T_DATA: begin
        if (tCnt_ff == 16'h0000 && tBit_ff == 3'h7) begin
          nxt_txOut = 1'b1;
          nxt_tState = T_STOP;
        end else if (tCnt_ff == 16'h0000) begin
          nxt_txOut = tSh_ff[0];
          nxt_tSh = {1'b0, tSh_ff[7:1]};
          nxt_tBit = tBit_ff + 3'h1;
        end
      end
      default: begin
        if (tCnt_ff == 16'h0000) begin
          nxt_tState = T_IDLE;
        end
      end
    endcase
    nxt_txOe = (nxt_tState != T_IDLE) || (rState_ff != R_IDLE) || bufOutValid;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tState_ff <= T_IDLE;
      tCnt_ff <= 16'h0000;
      tBit_ff <= 3'h0;
      tSh_ff <= 8'h00;
      txOut_ff <= 1'b1;
      txOe_ff <= 1'b0;
    end else begin
      tState_ff <= nxt_tState;
      tCnt_ff <= nxt_tCnt;
      tBit_ff <= nxt_tBit;
      tSh_ff <= nxt_tSh;
      txOut_ff <= nxt_txOut;
      txOe_ff <= nxt_txOe;
    end
  end

  assign txOut = txOut_ff;
  assign txOe = txOe_ff;
  assign measureStart = measure_ff;
  assign lrcError = lrcErr_ff;
  assign slaveAddr = slaveAddr_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  colon_restart_a: assert property (rxDone_ff && rxSh_ff == mbas_pkg::CH_COLON
    |=> pState_ff == P_BODY && nByte_ff == 4'h0 && !bad_ff) else $error("colon did not restart");
  lrc_flag_a: assert property (pState_ff == P_LF && rxDone_ff && rxSh_ff == mbas_pkg::CH_LF
    && frameOk && sum_ff != 8'h00 |=> lrcErr_ff && !reqGo_ff) else $error("bad check not flagged");
  zero_addr_a: assert property (rState_ff == R_IDLE && reqGo_ff && frm_ff[0] == 8'h00
    |=> rState_ff == R_COLON) else $error("address zero not answered");
  bcast_silent_a: assert property (rState_ff == R_IDLE && reqGo_ff
    && frm_ff[0] == mbas_pkg::ADDR_BCAST |=> rState_ff == R_IDLE) else $error("broadcast answered");
  read_limit_a: assert property (rState_ff == R_IDLE && reqGo_ff && fn == mbas_pkg::FN_READ
    && reqV > 16'h0010 |=> rExc_ff && rCode_ff == 8'h03 && rLen_ff == 6'h03)
    else $error("oversize read accepted");
  start_cmd_a: assert property (rState_ff == R_IDLE && reqGo_ff && fn == mbas_pkg::FN_WRITE
    && reqA == 16'h0200 && reqV == 16'h0001
    |=> measure_ff ##1 (!measure_ff || $past(trigFall)))
    else $error("start write did not pulse");
  trig_start_a: assert property ($fell(trLvl_ff) |-> measure_ff)
    else $error("trigger did not start");
  tx_release_a: assert property (tState_ff == T_IDLE && rState_ff == R_IDLE && !bufOutValid
    |=> !txOe_ff) else $error("driver held while idle");
  upper_hex_a: assert property (bufInValid |-> !(bufInData >= 8'h61 && bufInData <= 8'h66))
    else $error("lower case hex sent");
endmodule : mbas_slave_port
`default_nettype wire

//--- tb/mbas_master_model.sv
/* Serial master model for the slave port.
   Assumes the bench calls its tasks just after a rising mclk edge. */
`timescale 1ns/100ps
`default_nettype none
module mbas_master_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic mclk, // System clock.
  output logic rxIn, // Line into the slave.
  input wire logic txOut, // Slave transmit data.
  input wire logic txOe // Slave driver enable.
);
  logic [7:0] rxQ[$];
  initial rxIn = 1'b1;
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hx
  task automatic sendChar(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxIn <= f[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask : sendChar
  task automatic sendFrame(input logic [7:0] b[6], input logic bad);
    logic [7:0] s;
    s = 8'h00;
    sendChar(8'h3a);
    foreach (b[i]) begin
      s += b[i];
      sendChar(hx(b[i][7:4]));
      sendChar(hx(b[i][3:0]));
    end
    s = (8'h00 - s) ^ {7'h0, bad};
    sendChar(hx(s[7:4]));
    sendChar(hx(s[3:0]));
    sendChar(8'h0d);
    sendChar(8'h0a);
  endtask : sendFrame
  // A released line shows the inverse of its last level, so a cut reply gives wrong bits.
  logic line;
  assign line = (txOe === 1'b1) ? txOut : ~txOut;
  always begin : rxProc
    logic [7:0] c;
    @(posedge mclk);
    if (txOe === 1'b1 && line === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        c[i] = line;
      end
      repeat (BIT_CYC) @(posedge mclk);
      rxQ.push_back(c);
    end
  end
endmodule : mbas_master_model
`default_nettype wire

//--- tb/mbas_slave_port_tb_top.sv
/* Request and reply tests of the slave port.
   Assumes the master model and a shortened bit time. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errTotal++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module mbas_slave_port_tb_top;
  localparam int BC = 8;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic trigN = 1'b1;
  logic rxIn, txOut, txOe, measureStart, lrcError;
  logic [7:0] slaveAddr;
  logic [7:0] expB[$];
  int errTotal = 0, comparisons = 0, cyc = 0, starts = 0, lrcErrs = 0, n;
  mbas_slave_port #(.BIT_CYC(BC)) u_mbas_slave_port (.mclk(mclk), .resetn(resetn),
    .rxIn(rxIn), .trigN(trigN), .txOut(txOut), .txOe(txOe),
    .measureStart(measureStart), .lrcError(lrcError), .slaveAddr(slaveAddr));
  mbas_master_model #(.BIT_CYC(BC)) u_mbas_master_model (.mclk(mclk), .rxIn(rxIn),
    .txOut(txOut), .txOe(txOe));
  initial forever #5 mclk = ~mclk;
  task automatic stop_test();
    if (errTotal == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    cyc++;
    if (measureStart === 1'b1) starts++;
    if (lrcError === 1'b1) lrcErrs++;
    if (cyc == 60000) begin
      errTotal++;
      stop_test();
    end
  end
  // Sends one request and compares the whole reply with expB framed here.
  task automatic req(input logic [7:0] a, f, input logic [15:0] x, y, input logic bad);
    logic [7:0] e[$];
    logic [7:0] s;
    s = 8'h00;
    u_mbas_master_model.sendFrame('{a, f, x[15:8], x[7:0], y[15:8], y[7:0]}, bad);
    if (expB.size() > 0) e.push_back(8'h3a);
    foreach (expB[i]) begin
      s += expB[i];
      e.push_back(u_mbas_master_model.hx(expB[i][7:4]));
      e.push_back(u_mbas_master_model.hx(expB[i][3:0]));
    end
    s = 8'h00 - s;
    if (expB.size() > 0) e = {e, u_mbas_master_model.hx(s[7:4]),
      u_mbas_master_model.hx(s[3:0]), 8'h0d, 8'h0a};
    for (int i = 0; i < 400 && txOe !== 1'b1; i++) @(posedge mclk);
    for (int i = 0; i < 40000 && txOe === 1'b1; i++) @(posedge mclk);
    repeat (2 * BC) @(posedge mclk);
    `CHK("replyLen", e.size(), u_mbas_master_model.rxQ.size())
    foreach (e[i]) `CHK("replyChar", e[i], u_mbas_master_model.rxQ[i])
    `CHK("txOe", 1'b0, txOe)
    u_mbas_master_model.rxQ.delete();
    expB.delete();
  endtask : req
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    expB = '{8'h00, 8'h03, 8'h02, 8'h00, 8'h01};
    req(8'h00, 8'h03, 16'h00a5, 16'h0001, 1'b0);
    expB = '{8'h01, 8'h06, 8'h00, 8'h10, 8'h12, 8'h34};
    req(8'h01, 8'h06, 16'h0010, 16'h1234, 1'b0);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    expB = '{8'h01, 8'h03, 8'h02, 8'h12, 8'h34};
    req(8'h01, 8'h03, 16'h0010, 16'h0001, 1'b0);
    expB = '{8'h01, 8'h06, 8'h00, 8'ha5, 8'h00, 8'h09};
    req(8'h01, 8'h06, 16'h00a5, 16'h0009, 1'b0);
    `CHK("slaveAddr", 8'h09, slaveAddr)
    req(8'h01, 8'h03, 16'h0010, 16'h0001, 1'b0);
    n = lrcErrs;
    req(8'h09, 8'h06, 16'h0010, 16'h5555, 1'b1);
    `CHK("lrcErrs", n + 1, lrcErrs)
    u_mbas_master_model.sendChar(8'h3a);
    u_mbas_master_model.sendChar(8'h30);
    expB = '{8'h09, 8'h03, 8'h02, 8'h12, 8'h34};
    req(8'h09, 8'h03, 16'h0010, 16'h0001, 1'b0);
    n = starts;
    req(8'hff, 8'h06, 16'h0200, 16'h0001, 1'b0);
    `CHK("starts", n + 1, starts)
    trigN <= 1'b0;
    repeat (10) @(posedge mclk);
    trigN <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK("starts", n + 2, starts)
    expB = '{8'h09, 8'h83, 8'h03};
    req(8'h09, 8'h03, 16'h0010, 16'h0011, 1'b0);
    expB = '{8'h09, 8'h84, 8'h01};
    req(8'h09, 8'h04, 16'h0010, 16'h0001, 1'b0);
    expB = '{8'h09, 8'h83, 8'h02};
    req(8'h09, 8'h03, 16'h0200, 16'h0001, 1'b0);
    expB = '{8'h09, 8'h86, 8'h02};
    req(8'h09, 8'h06, 16'h0300, 16'h0001, 1'b0);
    stop_test();
  end
endmodule : mbas_slave_port_tb_top
`default_nettype wire
